/* design/gsdma_consts.svh */
// constants of the generic slave dma command and counter block
`ifndef GSDMA_CONSTS_SVH
`define GSDMA_CONSTS_SVH
`define GSDMA_CMD_OFS      12'h0230
`define GSDMA_CNT_OFS0     12'h0234
`define GSDMA_CNT_OFS1     12'h0235
`define GSDMA_CNT_OFS2     12'h0236
`define GSDMA_CNT_OFS3     12'h0237
`define GSDMA_OP_IN        8'h00
`define GSDMA_OP_OUT       8'h01
`define GSDMA_OP_VALIDATE  8'h0E
`define GSDMA_OP_CLEAR     8'h0F
`define GSDMA_OP_RESET     8'h11
`define GSDMA_OP_STOP      8'h13
`define GSDMA_CMD_READ_VAL 8'hFF
`define GSDMA_CNT_RST      32'h0000_0000
`define GSDMA_FIFO_BYTES   8
`define GSDMA_CLK_MHZ      250
`define GSDMA_DRAIN_NS     60
`define GSDMA_DRAIN_CYC    ((`GSDMA_DRAIN_NS * `GSDMA_CLK_MHZ) / 1000)
`endif

/* design/gsdma_pkg.sv */
// types of the generic slave dma command and counter block
package gsdma_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } gsdma_cpu_req_t;

  typedef enum logic [1:0] {
    GSDMA_IDLE     = 2'b00,
    GSDMA_IN_RUN   = 2'b01,
    GSDMA_IN_FLUSH = 2'b10,
    GSDMA_OUT_RUN  = 2'b11
  } gsdma_state_t;
endpackage

/* design/gsdma_sync2.sv */
// two flip-flop synchroniser, one per bit
`timescale 1ns/1ps
`default_nettype none
module gsdma_sync2 #(
  parameter int              WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        meta_reg[i] <= RST_VAL[i];
        q[i]        <= RST_VAL[i];
      end else begin
        meta_reg[i] <= d[i];
        q[i]        <= meta_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

/* design/gsdma_fifo.sv */
// small valid/ready fifo held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module gsdma_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wptr_reg;
  logic [AW:0]      rptr_reg;
  logic             push;
  logic             pop;

  // depth must be a power of two: the pointers wrap on their extra bit
  assign in_ready  = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wptr_reg != rptr_reg;
  assign out_data  = mem_reg[rptr_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_reg[wptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else if (flush) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* design/gsdma_core.sv */
// generic slave dma command decoder, byte counter and dma bus handshake
//
// Summary of operation
// - write-only 8-bit command register at 0x230
// - code 00h moves bus bytes into buffer
// - code 01h moves buffer bytes onto bus
// - code 0Eh validates endpoint buffer, debugging
// - code 0Fh clears transmit buffer only
// - transmit buffer also clears after usb send
// - code 11h returns core to reset
// - handshake pins held inactive during reset
// - code 13h halts running transfer
// - stop drops out data already prefetched into fifo
// - stop flushes in fifo into buffer
// - stop completion sets dedicated status bit
// - 32-bit counter reads remaining byte count
// - in fifo eight bytes, drained within 60ns
// - out buffer freed only after fifo drains
// - four readable writable lanes, reset zero
// - new count taken when top lane written
// - counter decrements, zero sets complete flag
// - command register reads back all ones
// - data bus undriven until out command runs
`timescale 1ns/1ps
`default_nettype none
`include "gsdma_consts.svh"
module gsdma_core
  import gsdma_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire gsdma_cpu_req_t cpu_req,
  output logic          [7:0] cpu_rdata,
  output logic                transfer_request,
  input  wire logic           transfer_acknowledge,
  input  wire logic           dma_rd_n,
  input  wire logic           dma_wr_n,
  input  wire logic     [7:0] dma_data_in,
  output logic          [7:0] dma_data_out,
  output logic                dma_data_oe,
  output logic                ep_wr_valid,
  input  wire logic           ep_wr_ready,
  output logic          [7:0] ep_wr_data,
  input  wire logic           ep_rd_valid,
  output logic                ep_rd_ready,
  input  wire logic     [7:0] ep_rd_data,
  input  wire logic           ep_tx_sent,
  output logic                ep_validate,
  output logic                ep_clear_tx,
  output logic                ep_release,
  output logic                transfer_complete_flag,
  input  wire logic           transfer_complete_clr,
  output logic                stop_done_flag,
  input  wire logic           stop_done_clr
);
  localparam int DRAIN_MAX = `GSDMA_DRAIN_CYC;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic       ack_s;
  logic       rd_n_s;
  logic       wr_n_s;
  logic [7:0] din_s;
  logic       rd_n_q;
  logic       wr_n_q;

  gsdma_sync2 #(
    .WIDTH   (11),
    .RST_VAL (11'h006)
  ) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     ({din_s_unused_guard(dma_data_in), dma_rd_n, dma_wr_n, transfer_acknowledge}),
    .q     ({din_s, rd_n_s, wr_n_s, ack_s})
  );

  function automatic logic [7:0] din_s_unused_guard(input logic [7:0] v);
    return v;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      rd_n_q <= rd_n_s;
      wr_n_q <= wr_n_s;
    end
  end

  // ****************************************************************
  // command decode
  // ****************************************************************
  gsdma_state_t state_reg;
  logic [31:0]  count_reg;
  logic [31:0]  fetch_left_reg;
  logic [7:0]   lane_reg [3];
  logic         stop_pend_reg;
  logic         cmd_wr;
  logic         soft_rst;
  logic         stop_cmd;
  logic         in_push;
  logic         out_pop;
  logic         byte_moved;
  logic         cnt_load;
  logic         ep_fetch;
  logic         fifo_in_valid;
  logic         fifo_in_ready;
  logic [7:0]   fifo_in_data;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [7:0]   fifo_out_data;
  logic         fifo_flush;

  assign cmd_wr   = cpu_req.wr && (cpu_req.addr == `GSDMA_CMD_OFS);
  assign soft_rst = cmd_wr && (cpu_req.wdata == `GSDMA_OP_RESET);
  assign stop_cmd = cmd_wr && (cpu_req.wdata == `GSDMA_OP_STOP);
  assign cnt_load = cpu_req.wr && (cpu_req.addr == `GSDMA_CNT_OFS3);

  // strobe edges count only while the controller acknowledges
  assign in_push    = (state_reg == GSDMA_IN_RUN) && wr_n_q && !wr_n_s && ack_s
                      && fifo_in_ready && (count_reg != '0);
  assign out_pop    = (state_reg == GSDMA_OUT_RUN) && !rd_n_q && rd_n_s && ack_s
                      && fifo_out_valid;
  assign byte_moved = in_push || out_pop;
  assign ep_fetch   = ep_rd_valid && ep_rd_ready;

  // ****************************************************************
  // transfer state
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= GSDMA_IDLE;
      stop_pend_reg <= 1'b0;
    end else if (soft_rst) begin
      state_reg     <= GSDMA_IDLE;
      stop_pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        GSDMA_IDLE: begin
          // codes other than the listed ones fall through untouched
          if (cmd_wr && cpu_req.wdata == `GSDMA_OP_IN) begin
            state_reg <= GSDMA_IN_RUN;
          end else if (cmd_wr && cpu_req.wdata == `GSDMA_OP_OUT) begin
            state_reg <= GSDMA_OUT_RUN;
          end
        end
        GSDMA_IN_RUN: begin
          if (stop_cmd) begin
            state_reg     <= GSDMA_IN_FLUSH;
            stop_pend_reg <= 1'b1;
          end else if (count_reg == '0) begin
            state_reg <= GSDMA_IN_FLUSH;
          end
        end
        GSDMA_IN_FLUSH: begin
          if (stop_cmd) begin
            stop_pend_reg <= 1'b1;
          end
          if (!fifo_out_valid) begin
            state_reg     <= GSDMA_IDLE;
            stop_pend_reg <= 1'b0;
          end
        end
        GSDMA_OUT_RUN: begin
          if (stop_cmd) begin
            state_reg <= GSDMA_IDLE;
          end else if (count_reg == '0 && !fifo_out_valid) begin
            state_reg <= GSDMA_IDLE;
          end
        end
        default: state_reg <= GSDMA_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // byte counter
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= `GSDMA_CNT_RST;
      lane_reg  <= '{default: 8'h00};
    end else if (soft_rst) begin
      count_reg <= `GSDMA_CNT_RST;
      lane_reg  <= '{default: 8'h00};
    end else begin
      if (cpu_req.wr && cpu_req.addr == `GSDMA_CNT_OFS0) begin
        lane_reg[0] <= cpu_req.wdata;
      end
      if (cpu_req.wr && cpu_req.addr == `GSDMA_CNT_OFS1) begin
        lane_reg[1] <= cpu_req.wdata;
      end
      if (cpu_req.wr && cpu_req.addr == `GSDMA_CNT_OFS2) begin
        lane_reg[2] <= cpu_req.wdata;
      end
      if (cnt_load) begin
        count_reg <= {cpu_req.wdata, lane_reg[2], lane_reg[1], lane_reg[0]};
      end else if (byte_moved) begin
        count_reg <= count_reg - 32'h0000_0001;
      end
    end
  end

  // bounds the prefetch so the buffer never gives up more than the count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_left_reg <= '0;
    end else if (soft_rst) begin
      fetch_left_reg <= '0;
    end else if (state_reg == GSDMA_IDLE && cmd_wr && cpu_req.wdata == `GSDMA_OP_OUT) begin
      fetch_left_reg <= count_reg;
    end else if (ep_fetch) begin
      fetch_left_reg <= fetch_left_reg - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // fifo and endpoint buffer side
  // ****************************************************************
  assign ep_rd_ready    = (state_reg == GSDMA_OUT_RUN) && !stop_cmd && fifo_in_ready
                          && (fetch_left_reg != '0);
  assign fifo_in_valid  = in_push || ep_fetch;
  assign fifo_in_data   = (state_reg == GSDMA_OUT_RUN) ? ep_rd_data : din_s;
  assign ep_wr_valid    = fifo_out_valid
                          && (state_reg == GSDMA_IN_RUN || state_reg == GSDMA_IN_FLUSH);
  assign ep_wr_data     = fifo_out_data;
  assign fifo_out_ready = (state_reg == GSDMA_OUT_RUN) ? out_pop : ep_wr_ready;
  // bytes already prefetched on a stopped out transfer are dropped
  assign fifo_flush     = soft_rst || ((state_reg == GSDMA_OUT_RUN) && stop_cmd);

  gsdma_fifo #(
    .WIDTH (8),
    .DEPTH (`GSDMA_FIFO_BYTES)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .flush     (fifo_flush),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************************************
  // dma bus pins
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_request <= 1'b0;
    end else if (soft_rst) begin
      transfer_request <= 1'b0;
    end else begin
      transfer_request <= ((state_reg == GSDMA_IN_RUN) && fifo_in_ready && count_reg != '0)
                          || ((state_reg == GSDMA_OUT_RUN) && fifo_out_valid);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dma_data_oe  <= 1'b0;
      dma_data_out <= 8'h00;
    end else begin
      dma_data_oe <= (state_reg == GSDMA_OUT_RUN) && !soft_rst;
      // the byte is frozen while the controller holds the read strobe
      if (rd_n_s) begin
        dma_data_out <= fifo_out_data;
      end
    end
  end

  // ****************************************************************
  // endpoint commands and status flags
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ep_validate <= 1'b0;
      ep_clear_tx <= 1'b0;
      ep_release  <= 1'b0;
    end else begin
      ep_validate <= cmd_wr && cpu_req.wdata == `GSDMA_OP_VALIDATE;
      ep_clear_tx <= (cmd_wr && cpu_req.wdata == `GSDMA_OP_CLEAR) || ep_tx_sent;
      ep_release  <= (state_reg == GSDMA_OUT_RUN) && !stop_cmd && !soft_rst
                     && count_reg == '0 && !fifo_out_valid;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_complete_flag <= 1'b0;
    end else if (soft_rst) begin
      transfer_complete_flag <= 1'b0;
    end else if (byte_moved && !cnt_load && count_reg == 32'h0000_0001) begin
      transfer_complete_flag <= 1'b1;
    end else if (transfer_complete_clr) begin
      transfer_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stop_done_flag <= 1'b0;
    end else if (soft_rst) begin
      stop_done_flag <= 1'b0;
    end else if ((stop_cmd && (state_reg == GSDMA_IDLE || state_reg == GSDMA_OUT_RUN))
                 || (state_reg == GSDMA_IN_FLUSH && !fifo_out_valid
                     && (stop_pend_reg || stop_cmd))) begin
      stop_done_flag <= 1'b1;
    end else if (stop_done_clr) begin
      stop_done_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // processor read port
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_req.rd) begin
      if (cpu_req.addr == `GSDMA_CMD_OFS) begin
        cpu_rdata <= `GSDMA_CMD_READ_VAL;
      end else if (cpu_req.addr == `GSDMA_CNT_OFS0) begin
        cpu_rdata <= count_reg[7:0];
      end else if (cpu_req.addr == `GSDMA_CNT_OFS1) begin
        cpu_rdata <= count_reg[15:8];
      end else if (cpu_req.addr == `GSDMA_CNT_OFS2) begin
        cpu_rdata <= count_reg[23:16];
      end else if (cpu_req.addr == `GSDMA_CNT_OFS3) begin
        cpu_rdata <= count_reg[31:24];
      end else begin
        cpu_rdata <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_cmd_read;
    cpu_req.rd && cpu_req.addr == `GSDMA_CMD_OFS |=> cpu_rdata == 8'hFF;
  endproperty
  a_cmd_read: assert property (p_cmd_read) else $error("command read not all ones");

  property p_count_load;
    cnt_load && !soft_rst |=>
      count_reg == {$past(cpu_req.wdata), $past(lane_reg[2]), $past(lane_reg[1]),
                    $past(lane_reg[0])};
  endproperty
  a_count_load: assert property (p_count_load) else $error("count not loaded");

  property p_low_lane;
    cpu_req.wr && cpu_req.addr == `GSDMA_CNT_OFS0 && !byte_moved && !soft_rst
      |=> $stable(count_reg);
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("low lane changed count");

  property p_decrement;
    byte_moved && !cnt_load && !soft_rst |=> count_reg == $past(count_reg) - 32'h0000_0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("count not decremented");

  property p_done_flag;
    byte_moved && !cnt_load && !soft_rst && count_reg == 32'h0000_0001
      |=> transfer_complete_flag;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("complete flag missed");

  property p_bus_idle;
    state_reg == GSDMA_IDLE ##1 state_reg == GSDMA_IDLE |-> !dma_data_oe;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("data bus driven while idle");

  property p_reserved;
    cmd_wr && state_reg == GSDMA_IDLE && cpu_req.wdata > 8'h01 && cpu_req.wdata != 8'h0E
      && cpu_req.wdata != 8'h0F && cpu_req.wdata != 8'h11 && cpu_req.wdata != 8'h13
      |=> state_reg == GSDMA_IDLE && !ep_validate && !$rose(stop_done_flag);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code acted");

  property p_drain;
    state_reg == GSDMA_IN_FLUSH && ep_wr_ready |->
      ##[0:DRAIN_MAX] (state_reg != GSDMA_IN_FLUSH || !ep_wr_ready);
  endproperty
  a_drain: assert property (p_drain) else $error("in fifo not drained in time");

  property p_release;
    ep_release |-> $past(!fifo_out_valid) && $past(count_reg) == '0;
  endproperty
  a_release: assert property (p_release) else $error("buffer freed too early");

  property p_soft_rst;
    soft_rst |=> state_reg == GSDMA_IDLE && count_reg == '0 && !transfer_request
                 && !dma_data_oe;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("dma reset incomplete");

  property p_stop_out;
    stop_cmd && state_reg == GSDMA_OUT_RUN && !stop_done_clr
      |=> stop_done_flag && !ep_release && state_reg == GSDMA_IDLE;
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("out stop wrong");
endmodule
`default_nettype wire

/* sim/gsdma_dma_ctl.sv */
// external dma controller model for the generic slave dma block
`timescale 1ns/1ps
`default_nettype none
module gsdma_dma_ctl (
  input  wire logic       mclk,
  input  wire logic       transfer_request,
  input  wire logic [7:0] dma_data_out,
  output logic            transfer_acknowledge,
  output logic            dma_rd_n,
  output logic            dma_wr_n,
  output logic      [7:0] dma_data_in
);
  // ***********************************
  // handshake, idle until a task runs
  // ***********************************
  initial begin
    transfer_acknowledge = 1'b0;
    dma_rd_n             = 1'b1;
    dma_wr_n             = 1'b1;
    dma_data_in          = 8'h00;
  end

  task automatic wait_req(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge mclk);
      ok = transfer_request;
    end
    transfer_acknowledge <= 1'b1;
  endtask

  // gap stretches the high phase to play a slow controller
  task automatic push(input logic [7:0] d, input int gap, output bit ok);
    wait_req(ok);
    dma_data_in <= d;
    @(posedge mclk);
    dma_wr_n <= 1'b0;
    repeat (4) @(posedge mclk);
    dma_wr_n <= 1'b1;
    repeat (4 + gap) @(posedge mclk);
    // released bus shows no stale byte
    dma_data_in          <= ~d;
    transfer_acknowledge <= 1'b0;
  endtask

  task automatic pull(output logic [7:0] d, input int gap, output bit ok);
    wait_req(ok);
    dma_rd_n <= 1'b0;
    repeat (4) @(posedge mclk);
    d = dma_data_out;
    dma_rd_n <= 1'b1;
    repeat (4 + gap) @(posedge mclk);
    transfer_acknowledge <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/gsdma_core_test.sv */
// self-checking bench for the generic slave dma command and counter block
`timescale 1ns/1ps
`default_nettype none
`include "gsdma_consts.svh"
module gsdma_core_test import gsdma_pkg::*;;
  gsdma_cpu_req_t cpu_req;
  logic [7:0]     cpu_rdata, dma_data_in, dma_data_out, ep_wr_data, ep_rd_data, rv;
  logic           mclk, rst_n, transfer_request, transfer_acknowledge, dma_rd_n, dma_wr_n;
  logic           dma_data_oe, ep_wr_valid, ep_wr_ready, ep_rd_valid, ep_rd_ready, ep_tx_sent;
  logic           ep_validate, ep_clear_tx, ep_release, transfer_complete_flag, stop_done_flag;
  logic           transfer_complete_clr, stop_done_clr;
  logic [7:0]     src [8];
  logic [7:0]     in_q [$];
  logic [7:0]     rsv [7] = '{8'h02, 8'h07, 8'h0D, 8'h10, 8'h12, 8'h14, 8'hFF};
  int             src_n, src_i, n_val, n_clr, n_rel, fail_count, num_checks;
  bit             ok;

  assign ep_rd_valid = (src_i < src_n);
  assign ep_rd_data  = src[src_i[2:0]];

  gsdma_core dut (.mclk(mclk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .transfer_request(transfer_request), .transfer_acknowledge(transfer_acknowledge),
    .dma_rd_n(dma_rd_n), .dma_wr_n(dma_wr_n), .dma_data_in(dma_data_in),
    .dma_data_out(dma_data_out), .dma_data_oe(dma_data_oe), .ep_wr_valid(ep_wr_valid),
    .ep_wr_ready(ep_wr_ready), .ep_wr_data(ep_wr_data), .ep_rd_valid(ep_rd_valid),
    .ep_rd_ready(ep_rd_ready), .ep_rd_data(ep_rd_data), .ep_tx_sent(ep_tx_sent),
    .ep_validate(ep_validate), .ep_clear_tx(ep_clear_tx), .ep_release(ep_release),
    .transfer_complete_flag(transfer_complete_flag),
    .transfer_complete_clr(transfer_complete_clr),
    .stop_done_flag(stop_done_flag), .stop_done_clr(stop_done_clr));

  gsdma_dma_ctl dma (.mclk(mclk), .transfer_request(transfer_request),
    .dma_data_out(dma_data_out), .transfer_acknowledge(transfer_acknowledge),
    .dma_rd_n(dma_rd_n), .dma_wr_n(dma_wr_n), .dma_data_in(dma_data_in));

  always #2 mclk = ~mclk;

  // ***********************************
  // endpoint buffer stand-in
  // ***********************************
  always @(posedge mclk) begin
    if (ep_wr_valid && ep_wr_ready) in_q.push_back(ep_wr_data);
    if (ep_rd_valid && ep_rd_ready) src_i <= src_i + 1;
    n_val <= n_val + int'(ep_validate);
    n_clr <= n_clr + int'(ep_clear_tx);
    n_rel <= n_rel + int'(ep_release);
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle;
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    cpu_req <= '0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge mclk);
    cpu_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    cpu_req <= '0;
    #1;
    chk("cpu_rdata", {24'h0, e}, {24'h0, cpu_rdata});
  endtask

  task automatic cnt_chk(input logic [31:0] e);
    for (int i = 0; i < 4; i++) rchk(`GSDMA_CNT_OFS0 + 12'(i), e[8*i +: 8]);
  endtask

  // lowest lane first, the top lane commits the count
  task automatic load(input logic [31:0] c);
    for (int i = 0; i < 4; i++) wr(`GSDMA_CNT_OFS0 + 12'(i), c[8*i +: 8]);
  endtask

  task automatic clr_flags;
    @(posedge mclk);
    transfer_complete_clr <= 1'b1;
    stop_done_clr         <= 1'b1;
    @(posedge mclk);
    transfer_complete_clr <= 1'b0;
    stop_done_clr         <= 1'b0;
    settle();
  endtask

  task automatic finish_test;
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test();
  end

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    {mclk, rst_n, ep_tx_sent, transfer_complete_clr, stop_done_clr} = '0;
    {cpu_req, src_n, src_i, n_val, n_clr, n_rel, fail_count, num_checks} = '0;
    ep_wr_ready = 1'b1;
    src = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h81, 8'h7E, 8'h00, 8'hFF};
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`GSDMA_CMD_OFS, `GSDMA_CMD_READ_VAL);
    cnt_chk(`GSDMA_CNT_RST);
    rchk(12'h0240, 8'h00);
    chk("dma_data_oe", 0, dma_data_oe);
    for (int i = 0; i < 3; i++) wr(`GSDMA_CNT_OFS0 + 12'(i), 8'h03 * 8'(i == 0));
    cnt_chk(0);
    wr(`GSDMA_CNT_OFS3, 8'h00);
    cnt_chk(3);
    foreach (rsv[i]) wr(`GSDMA_CMD_OFS, rsv[i]);
    settle();
    chk("transfer_request", 0, transfer_request);
    cnt_chk(3);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_IN);
    for (int i = 0; i < 3; i++) begin
      dma.push(8'hB0 + 8'(i), 3 * i, ok);
      chk("transfer_request", 1, ok);
    end
    repeat (`GSDMA_DRAIN_CYC) @(posedge mclk);
    #1;
    chk("in_count", 3, in_q.size());
    foreach (in_q[i]) chk("ep_wr_data", 8'hB0 + 8'(i), in_q[i]);
    cnt_chk(0);
    chk("transfer_complete_flag", 1, transfer_complete_flag);
    clr_flags();
    chk("transfer_complete_flag", 0, transfer_complete_flag);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_VALIDATE);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_CLEAR);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_CLEAR);
    @(posedge mclk);
    ep_tx_sent <= 1'b1;
    @(posedge mclk);
    ep_tx_sent <= 1'b0;
    repeat (3) settle();
    chk("ep_validate", 1, n_val);
    chk("ep_clear_tx", 3, n_clr);
    @(posedge mclk);
    src_n <= 6;
    load(2);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_OUT);
    repeat (3) settle();
    chk("dma_data_oe", 1, dma_data_oe);
    for (int i = 0; i < 2; i++) begin
      dma.pull(rv, 6 * i, ok);
      chk("transfer_request", 1, ok);
      chk("dma_data_out", src[i], rv);
    end
    for (int k = 0; k < 20 && n_rel == 0; k++) settle();
    chk("ep_release", 1, n_rel);
    chk("transfer_complete_flag", 1, transfer_complete_flag);
    repeat (2) settle();
    chk("dma_data_oe", 0, dma_data_oe);
    @(posedge mclk);
    src_i <= 0;
    load(4);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_OUT);
    dma.pull(rv, 0, ok);
    chk("transfer_request", 1, ok);
    chk("dma_data_out", src[0], rv);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_STOP);
    repeat (3) settle();
    chk("stop_done_flag", 1, stop_done_flag);
    chk("dma_data_oe", 0, dma_data_oe);
    chk("ep_release", 1, n_rel);
    chk("ep_left", 2, src_n - src_i);
    clr_flags();
    chk("stop_done_flag", 0, stop_done_flag);
    in_q.delete();
    load(4);
    @(posedge mclk);
    ep_wr_ready <= 1'b0;
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_IN);
    for (int i = 0; i < 2; i++) begin
      dma.push(8'hC0 + 8'(i), 0, ok);
      chk("transfer_request", 1, ok);
    end
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_STOP);
    @(posedge mclk);
    ep_wr_ready <= 1'b1;
    for (int k = 0; k < 15 && !stop_done_flag; k++) settle();
    repeat (2) settle();
    chk("in_count", 2, in_q.size());
    chk("stop_done_flag", 1, stop_done_flag);
    chk("transfer_request", 0, transfer_request);
    load(5);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_IN);
    dma.push(8'hD0, 0, ok);
    chk("transfer_request", 1, ok);
    wr(`GSDMA_CMD_OFS, `GSDMA_OP_RESET);
    settle();
    chk("stop_done_flag", 0, stop_done_flag);
    chk("transfer_request", 0, transfer_request);
    cnt_chk(0);
    finish_test();
  end
endmodule
`default_nettype wire
